// ### logic/cpu_register_set_pkg.sv
`default_nettype none
package cpu_register_set_pkg;
   localparam int DATA_W = 32;
   localparam int GEN_COUNT = 16;
   localparam int SEL_W = 4;
   localparam logic [3:0] INDEX_REG_SEL = 4'h0;
   localparam logic [3:0] STACK_REG_SEL = 4'hf;
   // status word layout; only the mask field resets to ones, all other bits reset to zero
   localparam int MASK_LSB = 4;
   localparam int MASK_W = 4;
   localparam logic [3:0] MASK_RESET = 4'hf;
   // bits of the status word that are implemented (T, S, Q, M, mask)
   localparam logic [31:0] STATE_IMPL = 32'h0000_03f3;
   localparam logic [31:0] STATE_RESET = 32'h0000_00f0;
   localparam logic [31:0] VECTOR_BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] GP_RESET = 32'h0000_0000;
   localparam logic [1:0] STACK_ALIGN_MASK = 2'h3;
   // control and system register selectors
   typedef enum logic [2:0]
   {
      CR_STATE = 3'b000,
      CR_GLOBAL = 3'b001,
      CR_VECTOR = 3'b010,
      CR_MULT_ACC_HIGH = 3'b011,
      CR_MULT_ACC_LOW = 3'b100,
      CR_LINK = 3'b101,
      CR_IPTR = 3'b110
   } ctl_sel_t;
   // width of a memory operand being loaded
   typedef enum logic [1:0]
   {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } load_size_t;
   // reset sequencing
   typedef enum logic [1:0]
   {
      ST_FETCH_SP = 2'b00,
      ST_FETCH_PC = 2'b01,
      ST_RUN = 2'b10
   } init_state_t;
endpackage : cpu_register_set_pkg
`default_nettype wire

// ### logic/cpu_register_set.sv
// Operation
// - sixteen 32-bit general registers for data and address work.
// - register zero also gives the index operand for indexed addressing.
// - some instructions implicitly use register zero as source or target.
// - register fifteen is the stack pointer for exception save/restore.
// - three 32-bit control registers: state word, global base, vector base.
// - global base gives base address for peripheral register transfers.
// - vector base gives the base address of the exception vector area.
// - four 32-bit system registers: mac high, mac low, link, pointer.
// - both mac registers receive multiply and multiply-accumulate results.
// - link captures return address on calls; pointer holds program flow.
// - after reset stack pointer loads from the vector address table.
// - after reset instruction pointer loads from the vector table.
// - reset sets four mask bits to ones, reserved bits cleared.
// - register operands are always handled as full 32-bit words.
// - byte and word memory loads are sign-extended to 32 bits.
// - stack accesses are long words at addresses that are multiples of 4; the code only flags other addresses on stackMisaligned.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set #(
   parameter int NUM_GEN = 16
)(
   input wire logic clk,
   input wire logic rst,
   // reset vector fetch from the vector address table
   output logic vecFetchReq,
   output logic vecFetchSel,
   input wire logic vecFetchValid,
   input wire logic [31:0] vecFetchData,
   output logic initDone,
   // general register read ports
   input wire logic [3:0] readSelA,
   output logic [31:0] readDataA,
   input wire logic [3:0] readSelB,
   output logic [31:0] readDataB,
   input wire logic implicitZeroSrc,
   output logic [31:0] indexOperand,
   output logic [31:0] stackPointer,
   // general register write port, optionally fed by a memory load
   input wire logic genWrite,
   input wire logic [3:0] genWriteSel,
   input wire logic implicitZeroDst,
   input wire logic [31:0] genWriteData,
   input wire logic memLoad,
   input wire logic [1:0] memLoadSize,
   // exception stack push/pop adjusts the stack pointer by one long word
   input wire logic stackPush,
   input wire logic stackPop,
   output logic [31:0] stackAccessAddr,
   output logic stackMisaligned,
   // control and system register port
   input wire logic ctlWrite,
   input wire logic [2:0] ctlWriteSel,
   input wire logic [31:0] ctlWriteData,
   input wire logic [2:0] ctlReadSel,
   output logic [31:0] ctlReadData,
   // dedicated update paths
   input wire logic macWrite,
   input wire logic [31:0] macHighIn,
   input wire logic [31:0] macLowIn,
   input wire logic callLink,
   input wire logic [31:0] returnAddr,
   input wire logic ptrLoad,
   input wire logic [31:0] ptrNext,
   output logic [31:0] processor_state_word,
   output logic [31:0] global_base_pointer,
   output logic [31:0] vector_table_base,
   output logic [31:0] mult_acc_high,
   output logic [31:0] mult_acc_low,
   output logic [31:0] subroutine_link_reg,
   output logic [31:0] instruction_pointer,
   output logic [3:0] interrupt_mask_bits
);
   // selectors are four bits wide, so only sixteen registers can be served
   if (NUM_GEN != cpu_register_set_pkg::GEN_COUNT)
   begin : gen_count_check
      $error("cpu_register_set: exactly sixteen general registers");
   end

   logic [31:0] genRegs_q [NUM_GEN];
   logic [31:0] genRegs_d [NUM_GEN];
   logic [31:0] state_q, state_d;
   logic [31:0] global_q, global_d;
   logic [31:0] vector_q, vector_d;
   logic [31:0] macHigh_q, macHigh_d;
   logic [31:0] macLow_q, macLow_d;
   logic [31:0] link_q, link_d;
   logic [31:0] iptr_q, iptr_d;
   cpu_register_set_pkg::init_state_t init_q, init_d;
   logic [31:0] loadValue;
   logic [3:0] dstSel;
   logic running;
   logic [31:0] spNow;

   assign running = (init_q == cpu_register_set_pkg::ST_RUN);
   assign spNow = genRegs_q[cpu_register_set_pkg::STACK_REG_SEL];

   // widen memory operands so registers always hold long words
   always_comb
   begin
      unique case (memLoadSize)
         cpu_register_set_pkg::SZ_BYTE:
            loadValue = {{24{genWriteData[7]}}, genWriteData[7:0]};
         cpu_register_set_pkg::SZ_WORD:
            loadValue = {{16{genWriteData[15]}}, genWriteData[15:0]};
         default:
            loadValue = genWriteData;
      endcase
      if (!memLoad)
         loadValue = genWriteData;
   end

   // implicit-zero instructions override the encoded destination
   assign dstSel = implicitZeroDst ? cpu_register_set_pkg::INDEX_REG_SEL
                                   : genWriteSel;

   always_comb
   begin
      init_d = init_q;
      for (int i = 0; i < NUM_GEN; i++)
         genRegs_d[i] = genRegs_q[i];
      unique case (init_q)
         cpu_register_set_pkg::ST_FETCH_SP:
         begin
            if (vecFetchValid)
            begin
               genRegs_d[cpu_register_set_pkg::STACK_REG_SEL] =
                  vecFetchData;
               init_d = cpu_register_set_pkg::ST_FETCH_PC;
            end
         end
         cpu_register_set_pkg::ST_FETCH_PC:
         begin
            if (vecFetchValid)
               init_d = cpu_register_set_pkg::ST_RUN;
         end
         cpu_register_set_pkg::ST_RUN:
         begin
            // one long word per exception save or restore
            if (stackPush)
               genRegs_d[cpu_register_set_pkg::STACK_REG_SEL] =
                  spNow - 32'h0000_0004;
            else if (stackPop)
               genRegs_d[cpu_register_set_pkg::STACK_REG_SEL] =
                  spNow + 32'h0000_0004;
            // explicit write wins over stack adjust if both hit register 15
            if (genWrite)
               genRegs_d[dstSel] = loadValue;
         end
         default:
            init_d = cpu_register_set_pkg::ST_FETCH_SP;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         init_q <= cpu_register_set_pkg::ST_FETCH_SP;
         for (int i = 0; i < NUM_GEN; i++)
            genRegs_q[i] <= cpu_register_set_pkg::GP_RESET;
      end
      else
      begin
         init_q <= init_d;
         for (int i = 0; i < NUM_GEN; i++)
            genRegs_q[i] <= genRegs_d[i];
      end
   end

   always_comb
   begin
      state_d = state_q;
      global_d = global_q;
      vector_d = vector_q;
      macHigh_d = macHigh_q;
      macLow_d = macLow_q;
      link_d = link_q;
      iptr_d = iptr_q;
      if (init_q == cpu_register_set_pkg::ST_FETCH_PC && vecFetchValid)
         iptr_d = vecFetchData;
      if (running)
      begin
         if (macWrite)
         begin
            macHigh_d = macHighIn;
            macLow_d = macLowIn;
         end
         if (callLink)
            link_d = returnAddr;
         if (ptrLoad)
            iptr_d = ptrNext;
         if (ctlWrite)
         begin
            unique case (ctlWriteSel)
               cpu_register_set_pkg::CR_STATE:
                  // reserved bits stay zero
                  state_d = ctlWriteData & cpu_register_set_pkg::STATE_IMPL;
               cpu_register_set_pkg::CR_GLOBAL: global_d = ctlWriteData;
               cpu_register_set_pkg::CR_VECTOR: vector_d = ctlWriteData;
               cpu_register_set_pkg::CR_MULT_ACC_HIGH: macHigh_d = ctlWriteData;
               cpu_register_set_pkg::CR_MULT_ACC_LOW: macLow_d = ctlWriteData;
               cpu_register_set_pkg::CR_LINK: link_d = ctlWriteData;
               cpu_register_set_pkg::CR_IPTR: iptr_d = ctlWriteData;
               default: state_d = state_q;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= cpu_register_set_pkg::STATE_RESET;
         global_q <= cpu_register_set_pkg::GP_RESET;
         vector_q <= cpu_register_set_pkg::VECTOR_BASE_RESET;
         macHigh_q <= cpu_register_set_pkg::GP_RESET;
         macLow_q <= cpu_register_set_pkg::GP_RESET;
         link_q <= cpu_register_set_pkg::GP_RESET;
         iptr_q <= cpu_register_set_pkg::GP_RESET;
      end
      else
      begin
         state_q <= state_d;
         global_q <= global_d;
         vector_q <= vector_d;
         macHigh_q <= macHigh_d;
         macLow_q <= macLow_d;
         link_q <= link_d;
         iptr_q <= iptr_d;
      end
   end

   assign vecFetchReq = !running;
   assign vecFetchSel = (init_q == cpu_register_set_pkg::ST_FETCH_PC);
   assign initDone = running;

   assign readDataA = implicitZeroSrc
      ? genRegs_q[cpu_register_set_pkg::INDEX_REG_SEL]
      : genRegs_q[readSelA];
   assign readDataB = genRegs_q[readSelB];
   assign indexOperand =
      genRegs_q[cpu_register_set_pkg::INDEX_REG_SEL];
   assign stackPointer = spNow;
   // a push stores below the current pointer, a pop reads at it
   assign stackAccessAddr = stackPush ? spNow - 32'h0000_0004 : spNow;
   assign stackMisaligned =
      |(spNow[1:0] & cpu_register_set_pkg::STACK_ALIGN_MASK);

   always_comb
   begin
      unique case (ctlReadSel)
         cpu_register_set_pkg::CR_STATE: ctlReadData = state_q;
         cpu_register_set_pkg::CR_GLOBAL: ctlReadData = global_q;
         cpu_register_set_pkg::CR_VECTOR: ctlReadData = vector_q;
         cpu_register_set_pkg::CR_MULT_ACC_HIGH: ctlReadData = macHigh_q;
         cpu_register_set_pkg::CR_MULT_ACC_LOW: ctlReadData = macLow_q;
         cpu_register_set_pkg::CR_LINK: ctlReadData = link_q;
         cpu_register_set_pkg::CR_IPTR: ctlReadData = iptr_q;
         default: ctlReadData = 32'h0000_0000;
      endcase
   end

   assign processor_state_word = state_q;
   assign global_base_pointer = global_q;
   assign vector_table_base = vector_q;
   assign mult_acc_high = macHigh_q;
   assign mult_acc_low = macLow_q;
   assign subroutine_link_reg = link_q;
   assign instruction_pointer = iptr_q;
   assign interrupt_mask_bits = state_q[cpu_register_set_pkg::MASK_LSB +:
                                        cpu_register_set_pkg::MASK_W];
endmodule : cpu_register_set
`default_nettype wire

// ### testbench/cpu_register_set_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_assertions #(
   parameter int NUM_GEN = 16
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic vecFetchReq,
   input wire logic vecFetchSel,
   input wire logic vecFetchValid,
   input wire logic [31:0] vecFetchData,
   input wire logic initDone,
   input wire logic [31:0] readDataA,
   input wire logic implicitZeroSrc,
   input wire logic [31:0] indexOperand,
   input wire logic [31:0] stackPointer,
   input wire logic genWrite,
   input wire logic [3:0] genWriteSel,
   input wire logic implicitZeroDst,
   input wire logic [31:0] genWriteData,
   input wire logic memLoad,
   input wire logic [1:0] memLoadSize,
   input wire logic stackPush,
   input wire logic stackMisaligned,
   input wire logic [31:0] processor_state_word,
   input wire logic [31:0] vector_table_base,
   input wire logic [31:0] instruction_pointer,
   input wire logic [3:0] interrupt_mask_bits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence spWord;
      vecFetchReq && vecFetchValid && !vecFetchSel;
   endsequence
   sequence ptrWord;
      vecFetchReq && vecFetchValid && vecFetchSel;
   endsequence
   sequence byteToZero;
      initDone && genWrite && implicitZeroDst && memLoad &&
         memLoadSize == 2'h0;
   endsequence
   AST_SP_LOAD: assert property (
      spWord |=> stackPointer == $past(vecFetchData))
      else $error("stack pointer not loaded from table");
   AST_PTR_LOAD: assert property (
      ptrWord |=> instruction_pointer == $past(vecFetchData))
      else $error("pointer not loaded from table");
   AST_MASK: assert property (
      interrupt_mask_bits == processor_state_word[7:4] &&
      (processor_state_word & ~cpu_register_set_pkg::STATE_IMPL) == 32'h0)
      else $error("state word mask or reserved bits wrong");
   AST_MASK_INIT: assert property (
      !initDone |-> interrupt_mask_bits == 4'hf)
      else $error("mask bits not all ones before start");
   AST_VEC_INIT: assert property (
      !initDone |-> vector_table_base == 32'h0)
      else $error("vector base not zero at start");
   AST_ZERO_SRC: assert property (
      implicitZeroSrc |-> readDataA == indexOperand)
      else $error("implicit source is not register zero");
   AST_BYTE_EXT: assert property (
      byteToZero |=> indexOperand ==
      {{24{$past(genWriteData[7])}}, $past(genWriteData[7:0])})
      else $error("byte load not sign extended");
   AST_PUSH: assert property (
      initDone && stackPush &&
      !(genWrite && !implicitZeroDst && genWriteSel == 4'hf)
      |=> stackPointer == $past(stackPointer) - 32'h4)
      else $error("push did not step one long word");
   AST_ALIGN: assert property (
      stackMisaligned == (stackPointer[1:0] != 2'h0))
      else $error("misalignment flag wrong");
endmodule : cpu_register_set_assertions
`default_nettype wire

// ### testbench/vector_table_model.sv
`timescale 1ns/1ps
`default_nettype none
module vector_table_model #(
   parameter logic [31:0] SP_VAL = 32'h0,
   parameter logic [31:0] PC_VAL = 32'h0
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic vecFetchReq,
   input wire logic vecFetchSel,
   output logic vecFetchValid,
   output logic [31:0] vecFetchData
);
   logic [2:0] cnt_q;
   // slow memory: answers every eighth cycle, data garbles in between
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         cnt_q <= 3'h0;
         vecFetchValid <= 1'b0;
         vecFetchData <= 32'h0;
      end
      else
      begin
         cnt_q <= cnt_q + 3'h1;
         vecFetchValid <= vecFetchReq && cnt_q == 3'h7;
         vecFetchData <= (vecFetchReq && cnt_q == 3'h7) ?
            (vecFetchSel ? PC_VAL : SP_VAL) : ~vecFetchData;
      end
endmodule : vector_table_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic vecFetchReq, vecFetchSel, vecFetchValid, initDone, implicitZeroSrc;
   logic genWrite, implicitZeroDst, memLoad, stackPush, stackPop, ctlWrite;
   logic macWrite, callLink, ptrLoad, stackMisaligned;
   logic [3:0] readSelA, readSelB, genWriteSel, interrupt_mask_bits;
   logic [1:0] memLoadSize;
   logic [2:0] ctlWriteSel, ctlReadSel;
   logic [31:0] vecFetchData, readDataA, readDataB, indexOperand, stackPointer;
   logic [31:0] genWriteData, stackAccessAddr, ctlWriteData, ctlReadData;
   logic [31:0] macHighIn, macLowIn, returnAddr, ptrNext, processor_state_word;
   logic [31:0] global_base_pointer, vector_table_base, mult_acc_high;
   logic [31:0] mult_acc_low, subroutine_link_reg, instruction_pointer, d;
   logic [31:0] shadow [16];
   int num_errors = 0;
   int check_count = 0;
   always #5 clk = ~clk;
   cpu_register_set dut (.clk, .rst, .vecFetchReq, .vecFetchSel,
      .vecFetchValid, .vecFetchData, .initDone, .readSelA, .readDataA,
      .readSelB, .readDataB, .implicitZeroSrc, .indexOperand, .stackPointer,
      .genWrite, .genWriteSel, .implicitZeroDst, .genWriteData, .memLoad,
      .memLoadSize, .stackPush, .stackPop, .stackAccessAddr, .stackMisaligned,
      .ctlWrite, .ctlWriteSel, .ctlWriteData, .ctlReadSel, .ctlReadData,
      .macWrite, .macHighIn, .macLowIn, .callLink, .returnAddr, .ptrLoad,
      .ptrNext, .processor_state_word, .global_base_pointer,
      .vector_table_base, .mult_acc_high, .mult_acc_low, .subroutine_link_reg,
      .instruction_pointer, .interrupt_mask_bits);
   vector_table_model #(.SP_VAL(32'h0000_ff00), .PC_VAL(32'h0000_0100))
      partner (.clk, .rst, .vecFetchReq, .vecFetchSel, .vecFetchValid,
      .vecFetchData);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   function automatic logic [31:0] sext(logic [31:0] v, logic [1:0] sz);
      return sz == 2'h0 ? {{24{v[7]}}, v[7:0]} :
         sz == 2'h1 ? {{16{v[15]}}, v[15:0]} : v;
   endfunction : sext
   // write then read back the target on port A
   task automatic gw(logic [3:0] s, logic [31:0] v, logic ml, logic [1:0] sz,
      logic z);
      @(posedge clk);
      genWrite <= 1'b1;
      {genWriteSel, genWriteData, memLoad, memLoadSize} <= {s, v, ml, sz};
      implicitZeroDst <= z;
      readSelA <= z ? 4'h0 : s;
      @(posedge clk);
      genWrite <= 1'b0;
      shadow[z ? 4'h0 : s] = sext(v, ml ? sz : 2'h2);
      @(negedge clk);
      chk(readDataA, shadow[z ? 4'h0 : s]);
   endtask : gw
   task automatic cw(logic [2:0] s, logic [31:0] v, logic [31:0] exp);
      @(posedge clk);
      {ctlWrite, ctlWriteSel, ctlReadSel, ctlWriteData} <= {1'b1, s, s, v};
      @(posedge clk);
      ctlWrite <= 1'b0;
      @(negedge clk);
      chk(ctlReadData, exp);
   endtask : cw
   initial
   begin
      {genWrite, implicitZeroDst, memLoad, stackPush, stackPop, ctlWrite} = '0;
      {macWrite, callLink, ptrLoad, implicitZeroSrc, readSelA, readSelB} = '0;
      {genWriteSel, memLoadSize, ctlWriteSel, ctlReadSel, genWriteData} = '0;
      {ctlWriteData, macHighIn, macLowIn, returnAddr, ptrNext} = '0;
      void'($urandom(26));
      repeat (8) @(posedge clk);
      chk({28'h0, interrupt_mask_bits}, 32'hf);
      chk(vector_table_base, 32'h0);
      rst <= 1'b0;
      for (int i = 0; i < 60 && initDone !== 1'b1; i++) @(posedge clk);
      // a fetch that never completes counts once and the run goes on
      if (initDone !== 1'b1)
         num_errors++;
      chk(stackPointer, 32'h0000_ff00);
      chk(instruction_pointer, 32'h0000_0100);
      $display("test reset fetch done");
      for (int r = 0; r < 16; r++) gw(4'(r), $urandom, 1'b0, 2'h2, 1'b0);
      for (int r = 0; r < 16; r++)
      begin
         @(posedge clk);
         readSelB <= 4'(r);
         @(negedge clk);
         chk(readDataB, shadow[r]);
      end
      chk(indexOperand, shadow[0]);
      $display("test general registers done");
      foreach (shadow[i]) d = $urandom;
      for (int k = 0; k < 12; k++) gw(4'h9, k[0] ? $urandom : {16'h0, 4'(k), 12'h880}, 1'b1, 2'(k % 3), k[2]);
      @(posedge clk);
      {readSelA, implicitZeroSrc} <= {4'h7, 1'b1};
      @(negedge clk);
      chk(readDataA, shadow[0]);
      @(posedge clk);
      implicitZeroSrc <= 1'b0;
      gw(4'hf, 32'h0000_2000, 1'b0, 2'h2, 1'b0);
      @(posedge clk);
      stackPush <= 1'b1;
      @(negedge clk);
      chk(stackAccessAddr, 32'h0000_1ffc);
      @(posedge clk);
      {stackPush, stackPop} <= 2'b01;
      @(negedge clk);
      chk(stackPointer, 32'h0000_1ffc);
      chk(stackAccessAddr, 32'h0000_1ffc);
      @(posedge clk);
      stackPop <= 1'b0;
      @(negedge clk);
      chk(stackPointer, 32'h0000_2000);
      gw(4'hf, 32'h0000_2002, 1'b0, 2'h2, 1'b0);
      chk({31'h0, stackMisaligned}, 32'h1);
      $display("test loads and stack done");
      for (int s = 0; s < 7; s++)
      begin
         d = $urandom;
         cw(3'(s), d, s == 0 ? d & cpu_register_set_pkg::STATE_IMPL : d);
      end
      cw(3'h7, d, 32'h0);
      cw(3'h0, 32'hffff_ffff, cpu_register_set_pkg::STATE_IMPL);
      chk(processor_state_word, cpu_register_set_pkg::STATE_IMPL);
      cw(3'h1, 32'h0000_f000, 32'h0000_f000);
      chk(global_base_pointer, 32'h0000_f000);
      cw(3'h2, 32'h0000_0400, 32'h0000_0400);
      chk(vector_table_base, 32'h0000_0400);
      // fresh, distinct values so a path that does not load is caught
      d = $urandom;
      @(posedge clk);
      {macWrite, callLink, ptrLoad} <= 3'b111;
      {macHighIn, macLowIn, returnAddr, ptrNext} <= {d, ~d, d ^ 32'h0f0f_0f0f,
         d + 32'h0000_0008};
      @(posedge clk);
      {macWrite, callLink, ptrLoad} <= 3'b000;
      @(negedge clk);
      chk(mult_acc_high, d);
      chk(mult_acc_low, ~d);
      chk(subroutine_link_reg, d ^ 32'h0f0f_0f0f);
      chk(instruction_pointer, d + 32'h0000_0008);
      $display("test control and system registers done");
      // reset again from loaded contents; writes must wait for the fetch
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      chk({28'h0, interrupt_mask_bits}, 32'hf);
      chk(vector_table_base, 32'h0);
      {rst, ctlWrite, ctlWriteSel, ctlWriteData} <= {2'b01, 3'h2, d};
      repeat (10) @(posedge clk);
      ctlWrite <= 1'b0;
      for (int i = 0; i < 60 && initDone !== 1'b1; i++) @(posedge clk);
      if (initDone !== 1'b1)
         num_errors++;
      @(negedge clk);
      chk(vector_table_base, 32'h0);
      chk(stackPointer, 32'h0000_ff00);
      chk(instruction_pointer, 32'h0000_0100);
      $display("test second reset done");
      print_verdict();
   end
endmodule : tb_top
bind cpu_register_set cpu_register_set_assertions #(.NUM_GEN(NUM_GEN)) sva
   (.clk, .rst, .vecFetchReq, .vecFetchSel, .vecFetchValid, .vecFetchData,
   .initDone, .readDataA, .implicitZeroSrc, .indexOperand, .stackPointer,
   .genWrite, .genWriteSel, .implicitZeroDst, .genWriteData, .memLoad,
   .memLoadSize, .stackPush, .stackMisaligned, .processor_state_word,
   .vector_table_base, .instruction_pointer, .interrupt_mask_bits);
`default_nettype wire
